//--- src/modeset_params.svh
`ifndef MODESET_PARAMS_SVH
`define MODESET_PARAMS_SVH
`define CLK_MHZ 100
`define IO_PWR_TIMEOUT_US 20
`define IO_PWR_TIMEOUT_TC_US 30
`define BUF_ACTIVE_TIMEOUT_US 500
`define VGA_OFF_WAIT_US 100
`define BUF_IDLE_WAIT_US 8
`define IO_PWR_CYC (`IO_PWR_TIMEOUT_US * `CLK_MHZ)
`define IO_PWR_TC_CYC (`IO_PWR_TIMEOUT_TC_US * `CLK_MHZ)
`define BUF_ACTIVE_CYC (`BUF_ACTIVE_TIMEOUT_US * `CLK_MHZ)
`define VGA_OFF_CYC (`VGA_OFF_WAIT_US * `CLK_MHZ)
`define BUF_IDLE_CYC (`BUF_IDLE_WAIT_US * `CLK_MHZ)
`define FRAME_CYC_DEFAULT 1666667
`define TC_LANES_MAX 3'h4
`define LANE_MODE_X4 2'h3
`define PORT_SEL_NONE 3'h0
`define VGA_SCREEN_OFF_BIT 5
`define ADDR_CTRL 4'h0
`define ADDR_CFG 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_ERR 4'h3
`define CTRL_START_EN 0
`define CTRL_START_DIS 1
`define CFG_TC_STATIC 0
`define CFG_VGA 1
`define CFG_PWR_IO_CTL 2
`define CFG_PLL_MAP 3
`define CFG_PFIT 4
`define CFG_PLL_SHARED 5
`define CFG_WELLS_SHARED 6
`define CFG_PORT_SEL_LSB 8
`define CFG_PORT_SEL_W 3
`endif

//--- src/modeset_pkg.sv
`default_nettype none
package modeset_pkg;
	typedef enum logic [15:0] {
		ST_IDLE = 16'h0001, ST_WELLS = 16'h0002, ST_LANES = 16'h0004, ST_PLL = 16'h0008,
		ST_IOPWR = 16'h0010, ST_PHYMODE = 16'h0020, ST_PIPE = 16'h0040, ST_PORT = 16'h0080,
		ST_D_VGA = 16'h0100, ST_D_TRANS = 16'h0200, ST_D_FUNC = 16'h0400, ST_D_PORT = 16'h0800,
		ST_D_IOPWR = 16'h1000, ST_D_PLL = 16'h2000, ST_D_TC = 16'h4000, ST_D_WELLS = 16'h8000
	} seq_state_e;
	typedef logic [3:0] step_code_t;
endpackage
`default_nettype wire

//--- src/tmds_port_modeset_sequencer.sv
// Operation
// - static type-c: enable aux io power in power-well step
// - static type-c: lane count set to max before pll enable
// - program pll only if not running; map to port when selectable
// - io power request, wait enabled; timeout 20 us or 30 us type-c
// - static type-c: phy lane mode x4 after io power, before pipe
// - pipe step starts with transcoder clock select to port clock
// - vga: clear screen-off bit 5, enable panel fitter
// - port function control enabled before transcoder config enable
// - non static type-c: power up all lanes before buffer enable
// - buffer enable then wait not idle, timeout 500 us
// - failing enable unwinds every stage already enabled except lane count and phy lane mode
// - vga disable: set screen-off bit 5, wait 100 us, then planes
// - after config clear wait off status, timeout two frame times
// - function control off with port select none, then panel fitter off
// - buffer off, wait 8 us or idle, then transcoder clock none
// - drop io power, unmap pll, stop pll only if unshared
// - static type-c disable: aux io off, then safe-state bit 0
// - release only power wells not still required
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "modeset_params.svh"
module tmds_port_modeset_sequencer
	import modeset_pkg::*;
#(
	parameter int FRAME_CYC = `FRAME_CYC_DEFAULT,
	parameter int BUF_ACTIVE_CYC = `BUF_ACTIVE_CYC,
	parameter int VGA_OFF_CYC = `VGA_OFF_CYC
) (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	input wire logic display_init_in,
	input wire logic audio_off_in,
	input wire logic pll_running_in,
	input wire logic io_pwr_enabled_in,
	input wire logic buf_idle_in,
	input wire logic trans_off_in,
	output logic power_wells_out,
	output logic aux_io_power_out,
	output logic [2:0] typec_main_link_lane_count_out,
	output logic pll_enable_out,
	output logic pll_map_out,
	output logic io_power_request_out,
	output logic [1:0] phy_lane_mode_out,
	output logic trans_clk_sel_out,
	output logic planes_enable_out,
	output logic vga_screen_off_out,
	output logic panel_fitter_out,
	output logic transcoder_port_function_control_out,
	output logic [2:0] port_select_field_out,
	output logic transcoder_config_out,
	output logic lane_power_down_config_out,
	output logic port_buffer_control_out,
	output logic typec_safe_state_bit_out,
	output logic busy_out,
	output logic done_out,
	output logic audio_allow_out
);
	seq_state_e state_reg;
	logic [31:0] cfg_reg;
	logic [20:0] timer_reg;
	logic [2:0] sub_reg;
	logic err_reg;
	step_code_t err_step_reg;
	logic failed_reg;
	logic [31:0] rdata_next;

	wire cfg_tc = cfg_reg[`CFG_TC_STATIC];
	wire cfg_vga = cfg_reg[`CFG_VGA];
	wire cfg_io = cfg_reg[`CFG_PWR_IO_CTL];
	wire cfg_map = cfg_reg[`CFG_PLL_MAP];
	wire cfg_pfit = cfg_reg[`CFG_PFIT] | cfg_vga;
	wire wr_ctrl = wr_in && addr_in == `ADDR_CTRL;
	wire start_en = wr_ctrl && wdata_in[`CTRL_START_EN] && display_init_in;
	wire start_dis = wr_ctrl && wdata_in[`CTRL_START_DIS] && audio_off_in;

	function automatic logic [3:0] code_of(input seq_state_e s);
		case (s)
			ST_IOPWR: code_of = 4'h1;
			ST_PORT: code_of = 4'h2;
			ST_D_TRANS: code_of = 4'h3;
			default: code_of = 4'h0;
		endcase
	endfunction

	wire [20:0] io_limit = cfg_tc ? 21'(`IO_PWR_TC_CYC) : 21'(`IO_PWR_CYC);
	// only a wait still unmet can time out, so a late success never raises the error
	wire timed_out = (state_reg == ST_IOPWR && cfg_io && !io_pwr_enabled_in && timer_reg >= io_limit) ||
		(state_reg == ST_PORT && sub_reg == 3'h2 && buf_idle_in && timer_reg >= 21'(BUF_ACTIVE_CYC)) ||
		(state_reg == ST_D_TRANS && sub_reg == 3'h2 && !trans_off_in && timer_reg >= 21'(FRAME_CYC));

	// one flat state register keeps ordering visible; disable stages clear their outputs whether on or not,
	// so unwind after a failure walks every stage; only the vga stage checks that planes are still on
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_IDLE;
			sub_reg <= 3'h0;
			timer_reg <= 21'h0;
			failed_reg <= 1'b0;
		end else begin
			timer_reg <= timer_reg + 21'h1;
			case (state_reg)
				ST_IDLE: begin
					timer_reg <= 21'h0;
					sub_reg <= 3'h0;
					if (start_en) begin
						state_reg <= ST_WELLS;
						failed_reg <= 1'b0;
					end else if (start_dis) begin
						state_reg <= ST_D_VGA;
						failed_reg <= 1'b0;
					end
				end
				ST_WELLS: state_reg <= ST_LANES;
				ST_LANES: state_reg <= ST_PLL;
				ST_PLL: begin
					timer_reg <= 21'h0;
					state_reg <= ST_IOPWR;
				end
				ST_IOPWR: begin
					if (!cfg_io || io_pwr_enabled_in) begin
						state_reg <= ST_PHYMODE;
					end else if (timed_out) begin
						state_reg <= ST_D_VGA;
						timer_reg <= 21'h0;
						failed_reg <= 1'b1;
					end
				end
				ST_PHYMODE: state_reg <= ST_PIPE;
				ST_PIPE: begin
					sub_reg <= sub_reg + 3'h1;
					if (sub_reg == 3'h3) begin
						sub_reg <= 3'h0;
						state_reg <= ST_PORT;
					end
				end
				ST_PORT: begin
					if (sub_reg != 3'h2) begin
						sub_reg <= sub_reg + 3'h1;
						timer_reg <= 21'h0;
					end else if (!buf_idle_in) begin
						state_reg <= ST_IDLE;
					end else if (timed_out) begin
						// fresh timer so the vga screen-off wait is not skipped on unwind
						state_reg <= ST_D_VGA;
						timer_reg <= 21'h0;
						failed_reg <= 1'b1;
					end
				end
				ST_D_VGA: begin
					if (!cfg_vga || !planes_enable_out || timer_reg >= 21'(VGA_OFF_CYC)) begin
						state_reg <= ST_D_TRANS;
						timer_reg <= 21'h0;
						sub_reg <= 3'h0;
					end
				end
				ST_D_TRANS: begin
					if (sub_reg == 3'h0) begin
						sub_reg <= 3'h1;
						timer_reg <= 21'h0;
					end else if (trans_off_in || timed_out) begin
						state_reg <= ST_D_FUNC;
						sub_reg <= 3'h0;
					end else if (sub_reg == 3'h1 && timer_reg >= 21'(FRAME_CYC - 1)) begin
						// two frames counted one at a time so the timer stays narrow
						sub_reg <= 3'h2;
						timer_reg <= 21'h0;
					end
				end
				ST_D_FUNC: begin
					sub_reg <= sub_reg + 3'h1;
					if (sub_reg == 3'h1) begin
						state_reg <= ST_D_PORT;
						sub_reg <= 3'h0;
						timer_reg <= 21'h0;
					end
				end
				ST_D_PORT: begin
					if (sub_reg == 3'h0) begin
						sub_reg <= 3'h1;
						timer_reg <= 21'h0;
					end else if (buf_idle_in || timer_reg >= 21'(`BUF_IDLE_CYC)) begin
						state_reg <= ST_D_IOPWR;
					end
				end
				ST_D_IOPWR: state_reg <= ST_D_PLL;
				ST_D_PLL: state_reg <= ST_D_TC;
				ST_D_TC: state_reg <= ST_D_WELLS;
				ST_D_WELLS: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// power, pll and port controls
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			power_wells_out <= 1'b0;
			aux_io_power_out <= 1'b0;
			typec_main_link_lane_count_out <= 3'h0;
			pll_enable_out <= 1'b0;
			pll_map_out <= 1'b0;
			io_power_request_out <= 1'b0;
			phy_lane_mode_out <= 2'h0;
			lane_power_down_config_out <= 1'b1;
			port_buffer_control_out <= 1'b0;
			typec_safe_state_bit_out <= 1'b0;
		end else begin
			case (state_reg)
				ST_WELLS: begin
					power_wells_out <= 1'b1;
					if (cfg_tc) aux_io_power_out <= 1'b1;
					// port claimed for the static link until disable releases it
					if (cfg_tc) typec_safe_state_bit_out <= 1'b1;
				end
				ST_LANES: if (cfg_tc) typec_main_link_lane_count_out <= `TC_LANES_MAX;
				ST_PLL: begin
					if (!pll_running_in) pll_enable_out <= 1'b1;
					if (cfg_map) pll_map_out <= 1'b1;
					if (cfg_io) io_power_request_out <= 1'b1;
				end
				ST_PHYMODE: if (cfg_tc) phy_lane_mode_out <= `LANE_MODE_X4;
				ST_PORT: begin
					if (sub_reg == 3'h0 && !cfg_tc) lane_power_down_config_out <= 1'b0;
					if (sub_reg == 3'h1) port_buffer_control_out <= 1'b1;
				end
				ST_D_PORT: if (sub_reg == 3'h0) port_buffer_control_out <= 1'b0;
				ST_D_IOPWR: begin
					io_power_request_out <= 1'b0;
					pll_map_out <= 1'b0;
				end
				ST_D_PLL: if (!cfg_reg[`CFG_PLL_SHARED]) pll_enable_out <= 1'b0;
				ST_D_TC: begin
					if (cfg_tc) aux_io_power_out <= 1'b0;
					lane_power_down_config_out <= 1'b1;
				end
				ST_D_WELLS: begin
					// safe-state cleared one step after aux power goes off
					if (cfg_tc) typec_safe_state_bit_out <= 1'b0;
					if (!cfg_reg[`CFG_WELLS_SHARED]) power_wells_out <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// pipe and transcoder controls
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			trans_clk_sel_out <= 1'b0;
			planes_enable_out <= 1'b0;
			vga_screen_off_out <= 1'b1;
			panel_fitter_out <= 1'b0;
			transcoder_port_function_control_out <= 1'b0;
			port_select_field_out <= `PORT_SEL_NONE;
			transcoder_config_out <= 1'b0;
		end else begin
			case (state_reg)
				ST_PIPE: begin
					case (sub_reg)
						3'h0: trans_clk_sel_out <= 1'b1;
						3'h1: begin
							planes_enable_out <= 1'b1;
							if (cfg_vga) vga_screen_off_out <= 1'b0;
							if (cfg_pfit) panel_fitter_out <= 1'b1;
						end
						3'h2: begin
							transcoder_port_function_control_out <= 1'b1;
							port_select_field_out <= cfg_reg[`CFG_PORT_SEL_LSB +: `CFG_PORT_SEL_W];
						end
						3'h3: transcoder_config_out <= 1'b1;
						default: ;
					endcase
				end
				ST_D_VGA: if (cfg_vga && planes_enable_out) vga_screen_off_out <= 1'b1;
				ST_D_TRANS: if (sub_reg == 3'h0) begin
					planes_enable_out <= 1'b0;
					transcoder_config_out <= 1'b0;
				end
				ST_D_FUNC: begin
					if (sub_reg == 3'h0) begin
						transcoder_port_function_control_out <= 1'b0;
						port_select_field_out <= `PORT_SEL_NONE;
					end else begin
						panel_fitter_out <= 1'b0;
					end
				end
				ST_D_IOPWR: trans_clk_sel_out <= 1'b0;
				default: ;
			endcase
		end
	end

	// status, config and sticky error
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg_reg <= 32'h0;
			err_reg <= 1'b0;
			err_step_reg <= 4'h0;
			done_out <= 1'b0;
			busy_out <= 1'b0;
			audio_allow_out <= 1'b0;
			rdata_out <= 32'h0;
		end else begin
			if (wr_in && addr_in == `ADDR_CFG && state_reg == ST_IDLE) cfg_reg <= wdata_in;
			// set wins over a clear in the same cycle
			if (timed_out) begin
				err_reg <= 1'b1;
				err_step_reg <= code_of(state_reg);
			end else if (wr_in && addr_in == `ADDR_ERR && wdata_in[0]) begin
				err_reg <= 1'b0;
				err_step_reg <= 4'h0;
			end
			busy_out <= state_reg != ST_IDLE && !(state_reg == ST_D_WELLS);
			if (start_en || start_dis) done_out <= 1'b0;
			else if (state_reg == ST_D_WELLS || (state_reg == ST_PORT && sub_reg == 3'h2 && !buf_idle_in))
				done_out <= 1'b1;
			audio_allow_out <= (state_reg == ST_PORT && sub_reg == 3'h2 && !buf_idle_in) ||
				(audio_allow_out && state_reg == ST_IDLE && !start_dis);
			rdata_out <= rd_in ? rdata_next : 32'h0;
		end
	end

	always_comb begin
		case (addr_in)
			`ADDR_CFG: rdata_next = cfg_reg;
			`ADDR_STATUS: rdata_next = {27'h0, failed_reg, audio_allow_out, err_reg, done_out, busy_out};
			`ADDR_ERR: rdata_next = {27'h0, err_step_reg, err_reg};
			default: rdata_next = 32'h0;
		endcase
	end

	property p_refuse;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(state_reg == ST_IDLE && wr_ctrl && wdata_in[0] && !display_init_in && !wdata_in[1]) |=> state_reg == ST_IDLE;
	endproperty
	a_refuse: assert property (p_refuse) else $error("enable started without init");
	property p_clk_first;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		$rose(planes_enable_out) |-> trans_clk_sel_out;
	endproperty
	a_clk_first: assert property (p_clk_first) else $error("planes before clock select");
	property p_func_before_conf;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		$rose(transcoder_config_out) |-> $past(transcoder_port_function_control_out);
	endproperty
	a_func_before_conf: assert property (p_func_before_conf) else $error("config before func ctl");
	property p_lanes_before_buf;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		($rose(port_buffer_control_out) && !cfg_tc) |-> !lane_power_down_config_out;
	endproperty
	a_lanes_before_buf: assert property (p_lanes_before_buf) else $error("buffer on with lanes down");
	property p_io_timeout;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(state_reg == ST_IOPWR && timer_reg == io_limit && !io_pwr_enabled_in && cfg_io) |=> err_reg && err_step_reg == 4'h1;
	endproperty
	a_io_timeout: assert property (p_io_timeout) else $error("io power timeout missed");
	property p_tc_lanes;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		($rose(pll_enable_out) && cfg_tc) |-> typec_main_link_lane_count_out == `TC_LANES_MAX;
	endproperty
	a_tc_lanes: assert property (p_tc_lanes) else $error("pll on before lane count");
	property p_pfit_order;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		$fell(panel_fitter_out) |-> !transcoder_port_function_control_out && port_select_field_out == `PORT_SEL_NONE;
	endproperty
	a_pfit_order: assert property (p_pfit_order) else $error("pfit off before func ctl");
	property p_clk_none;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		$fell(trans_clk_sel_out) |-> !port_buffer_control_out;
	endproperty
	a_clk_none: assert property (p_clk_none) else $error("clock removed with buffer on");
	property p_err_sticky;
		@(posedge core_clk_in) disable iff (!rst_b_in)
		(err_reg && !(wr_in && addr_in == `ADDR_ERR)) |=> err_reg;
	endproperty
	a_err_sticky: assert property (p_err_sticky) else $error("error flag lost");
	c_enable: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(audio_allow_out));
	c_unwind: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) $rose(failed_reg));
	c_disable: cover property (@(posedge core_clk_in) disable iff (!rst_b_in) state_reg == ST_D_WELLS && !failed_reg);
endmodule // tmds_port_modeset_sequencer
`default_nettype wire

//--- sim/port_far_side_model.sv
`timescale 1ns/10ps
`default_nettype none
module port_far_side_model (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic io_req_in,
	input wire logic buffer_in,
	input wire logic config_in,
	input wire logic pll_en_in,
	input wire logic [3:0] hold_in,
	input wire logic [2:0] dly_in,
	output logic io_ok_out,
	output logic buf_idle_out,
	output logic trans_off_out,
	output logic pll_run_out
);
	logic [3:0] tgt;
	logic [3:0] now_reg;
	logic [2:0] cnt_reg [4];
	// each status follows its control after dly_in + 1 cycles
	assign tgt = {pll_en_in, ~config_in, ~buffer_in, io_req_in};
	assign {pll_run_out, trans_off_out, buf_idle_out, io_ok_out} = now_reg;
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			now_reg <= 4'h6;
			for (int i = 0; i < 4; i++) begin
				cnt_reg[i] <= 3'h0;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				// a held bit freezes: how a stuck status is staged
				if (hold_in[i] || now_reg[i] == tgt[i]) begin
					cnt_reg[i] <= 3'h0;
				end else if (cnt_reg[i] >= dly_in) begin
					now_reg[i] <= tgt[i];
					cnt_reg[i] <= 3'h0;
				end else begin
					cnt_reg[i] <= cnt_reg[i] + 3'h1;
				end
			end
		end
	end
endmodule // port_far_side_model
`default_nettype wire

//--- sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "modeset_params.svh"
module tb;
	localparam int FRAME = 50;
	localparam int BUF_ACT = 100;
	localparam int VGA_OFF = 20;
	logic core_clk_in, rst_b_in, wr_in, rd_in, display_init_in, audio_off_in;
	logic [3:0] addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic pll_running_in, io_pwr_enabled_in, buf_idle_in, trans_off_in;
	logic power_wells_out, aux_io_power_out, pll_enable_out, pll_map_out, io_power_request_out;
	logic [2:0] typec_main_link_lane_count_out, port_select_field_out;
	logic [1:0] phy_lane_mode_out;
	logic trans_clk_sel_out, planes_enable_out, vga_screen_off_out, panel_fitter_out;
	logic transcoder_port_function_control_out, transcoder_config_out, lane_power_down_config_out;
	logic port_buffer_control_out, typec_safe_state_bit_out, busy_out, done_out, audio_allow_out;
	logic [3:0] hold;
	logic [2:0] dly;
	logic [31:0] seed, sel;
	logic tc, vga, rd_q;
	logic [31:0] expq[$];
	int fails, samples_checked, n, vcnt;
	int lim [3] = '{2000, BUF_ACT, 2 * FRAME};

	tmds_port_modeset_sequencer #(.FRAME_CYC(FRAME), .BUF_ACTIVE_CYC(BUF_ACT), .VGA_OFF_CYC(VGA_OFF))
	tmds_port_modeset_sequencer_inst (.core_clk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out, .display_init_in, .audio_off_in, .pll_running_in, .io_pwr_enabled_in, .buf_idle_in,
		.trans_off_in, .power_wells_out, .aux_io_power_out, .typec_main_link_lane_count_out,
		.pll_enable_out, .pll_map_out, .io_power_request_out, .phy_lane_mode_out, .trans_clk_sel_out,
		.planes_enable_out, .vga_screen_off_out, .panel_fitter_out, .transcoder_port_function_control_out,
		.port_select_field_out, .transcoder_config_out, .lane_power_down_config_out,
		.port_buffer_control_out, .typec_safe_state_bit_out, .busy_out, .done_out, .audio_allow_out);

	port_far_side_model port_far_side_model_inst (.clk_in(core_clk_in), .rst_b_in,
		.io_req_in(io_power_request_out), .buffer_in(port_buffer_control_out),
		.config_in(transcoder_config_out), .pll_en_in(pll_enable_out), .hold_in(hold), .dly_in(dly),
		.io_ok_out(io_pwr_enabled_in), .buf_idle_out(buf_idle_in), .trans_off_out(trans_off_in),
		.pll_run_out(pll_running_in));

	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize;
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge core_clk_in);
		wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge core_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		expq.push_back(e);
		@(posedge core_clk_in);
		rd_in <= 1'b0;
	endtask

	// busy lags the state, so give it four edges before counting
	task automatic go(input logic [31:0] cmd, output int cyc);
		cyc = 0;
		wr(4'h0, cmd);
		repeat (4) @(posedge core_clk_in);
		while (busy_out === 1'b1 && cyc < 20000) begin
			@(posedge core_clk_in);
			cyc++;
		end
		if (cyc >= 20000) fails++;
	endtask

	always @(posedge core_clk_in) begin
		rd_q <= rd_in;
		if (rd_q) chk("rdata", expq.pop_front(), rdata_out);
		vcnt <= vga_screen_off_out ? vcnt + 1 : 0;
		if (rst_b_in === 1'b1) begin
			if ($rose(pll_enable_out) && tc) chk("lane_count", `TC_LANES_MAX, typec_main_link_lane_count_out);
			if ($rose(planes_enable_out)) chk("clk_sel", 1, trans_clk_sel_out);
			if ($rose(planes_enable_out) && tc) chk("phy_mode", `LANE_MODE_X4, phy_lane_mode_out);
			if ($rose(transcoder_config_out)) chk("func_ctl", 1, transcoder_port_function_control_out);
			if ($rose(port_buffer_control_out) && !tc) chk("lanes_dn", 0, lane_power_down_config_out);
			if ($fell(planes_enable_out) && vga) chk("off_wait", 1, 32'(vcnt >= VGA_OFF));
			if ($fell(panel_fitter_out)) chk("func_off", 0, {transcoder_port_function_control_out,
				port_select_field_out});
			if ($fell(trans_clk_sel_out)) chk("buf_off", 0, port_buffer_control_out);
			if ($fell(typec_safe_state_bit_out)) chk("safe_order", 0, aux_io_power_out);
		end
	end

	// whole run is a few thousand cycles; 50k means a hang
	initial begin
		#500000;
		fails++;
		summarize();
	end

	initial begin
		seed = 32'hc605;
		fails = 0;
		samples_checked = 0;
		{addr_in, wdata_in, wr_in, rd_in, display_init_in, audio_off_in, hold, tc, vga} = '0;
		dly = 3'h1;
		rst_b_in = 1'b0;
		repeat (8) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		@(posedge core_clk_in);
		chk("rst_vals", 32'h3, {port_buffer_control_out, pll_enable_out, vga_screen_off_out,
			lane_power_down_config_out});
		rd(4'h2, 32'h0);
		rd(4'hf, 32'h0);
		seed = xs(seed);
		sel = seed % 7 + 1;
		dly <= seed[10:8];
		tc = 1'b1;
		vga = 1'b1;
		wr(4'h1, 32'h1f | (sel << 8));
		go(32'h1, n);
		chk("refused", 0, n);
		display_init_in <= 1'b1;
		go(32'h1, n);
		chk("aux_io", 32'h3, {aux_io_power_out, typec_safe_state_bit_out});
		chk("pll_map", 32'h3, {pll_enable_out, pll_map_out});
		chk("io_req", 1, io_power_request_out);
		chk("vga_pfit", 32'h1, {vga_screen_off_out, panel_fitter_out});
		chk("port_sel", sel, port_select_field_out);
		chk("buffer", 1, port_buffer_control_out);
		rd(4'h2, 32'ha);
		go(32'h2, n);
		chk("dis_refused", 0, n);
		audio_off_in <= 1'b1;
		go(32'h2, n);
		chk("pll_io_off", 0, {pll_enable_out, pll_map_out, io_power_request_out});
		chk("aux_safe", 0, {aux_io_power_out, typec_safe_state_bit_out});
		chk("wells", 0, power_wells_out);
		chk("clk_none", 0, {trans_clk_sel_out, port_select_field_out});
		tc = 1'b0;
		vga = 1'b0;
		seed = xs(seed);
		dly <= seed[2:0];
		wr(4'h1, 32'h6c | (sel << 8));
		go(32'h1, n);
		chk("aux_nontc", 0, {aux_io_power_out, typec_safe_state_bit_out});
		go(32'h2, n);
		chk("shared", 32'h3, {pll_enable_out, power_wells_out});
		for (int k = 1; k <= 3; k++) begin
			wr(4'h1, 32'h0c);
			if (k == 3) go(32'h1, n);
			// let every status follow its control before one is frozen
			repeat (8) @(posedge core_clk_in);
			hold <= 4'(1 << (k - 1));
			go((k == 3) ? 32'h2 : 32'h1, n);
			chk("span", 1, 32'(n >= lim[k - 1] - 8));
			rd(4'h3, 32'((k << 1) | 1));
			chk("unwound", 0, {port_buffer_control_out, pll_enable_out, power_wells_out});
			wr(4'h3, 32'h1);
			rd(4'h3, 32'h0);
			hold <= 4'h0;
		end
		repeat (4) @(posedge core_clk_in);
		summarize();
	end
endmodule // tb
`default_nettype wire
